// >>> inc/stp_defs.svh
`ifndef STP_DEFS_SVH
`define STP_DEFS_SVH
// Byte offsets inside one port bank; port 1 bank sits at the stride
`define STP_PORT_STRIDE 8'h40
`define STP_CTRL_OFS 8'h00
`define STP_COUNT_OFS 8'h04
`define STP_WAIT_OFS 8'h08
`define STP_FLUSH_OFS 8'h0C
`define STP_ATTN_OFS 8'h10
`define STP_BAUD_OFS 8'h14
`define STP_DIP_OFS 8'h18
`define STP_DPORT_OFS 8'h1C
`define STP_STAT_OFS 8'h20
`define STP_LIP_OFS 8'h24
// Control word field positions
`define STP_C_UDP 0
`define STP_C_LEARN 1
`define STP_C_PKTEN 2
`define STP_C_ATEN 3
`define STP_C_MODE 4
`define STP_C_FLOW 6
`define STP_C_BITS 8
`define STP_C_STOP2 10
`define STP_C_PAR 11
`define STP_C_BCUST 13
`define STP_C_BIDX 14
// Status word field positions
`define STP_S_BUSY 8
`define STP_S_ATTN 9
// Reset values: 8 data bits, 115200 baud, other control bits and flush off; count 50, wait 100 ms, attention 2B
`define STP_CTRL_RST 16'hC300
`define STP_COUNT_RST 8'h32
`define STP_WAIT_RST 16'h0064
`define STP_FLUSH_RST 9'h000
`define STP_ATTN_RST 8'h2B
// Serial mode and flow codes
`define STP_MODE_RS232 2'h0
`define STP_MODE_DEBUG 2'h1
`define STP_FLOW_NONE 2'h0
`define STP_FLOW_XON 2'h1
`define STP_FLOW_RTS 2'h2
// Standard baud table, indexed by the two-bit rate select
`define STP_BAUD0 32'h0000_2580
`define STP_BAUD1 32'h0000_4B00
`define STP_BAUD2 32'h0000_E100
`define STP_BAUD3 32'h0001_C200
// Buffer depth per port and millisecond timing
`define STP_BUF_DEPTH 128
`define STP_CLK_PERIOD_NS 10
`define STP_MS_NS 1000000
`define STP_MS_CYCLES (`STP_MS_NS / `STP_CLK_PERIOD_NS)
`endif

// >>> inc/stp_pkg.sv
`include "stp_defs.svh"
package stp_pkg;
  // Per-port frame machine phases
  typedef enum logic [1:0] {STP_COLLECT, STP_FETCH, STP_OFFER} stp_phase_t;
  // Per-port registers and frame state
  typedef struct packed {
    logic [15:0] ctrl;
    logic [7:0] countThr;
    logic [15:0] waitMs;
    logic [8:0] flush;
    logic [7:0] attnChar;
    logic [31:0] custBaud;
    logic [31:0] destIp;
    logic [15:0] destPort;
    logic [31:0] learnedIp;
    logic attnSeen;
    logic attnHit;
    logic [7:0] fill;
    logic [7:0] sendIdx;
    logic [15:0] msCnt;
    logic timing;
    stp_phase_t phase;
  } stp_port_t;
  // Whole state of the packetizer
  typedef struct packed {
    stp_port_t [1:0] port;
    logic [16:0] msPre;
    logic msTick;
    logic [31:0] rdWord;
    logic badAddr;
  } stp_state_t;
  // Character store of one port
  typedef struct packed {
    logic [`STP_BUF_DEPTH-1:0][7:0] cells;
    logic [7:0] rdData;
  } stp_mem_t;
endpackage

// >>> inc/stp_mem_if.sv
`timescale 1ns/1ps
interface stp_mem_if;
  logic wrEn;
  logic [6:0] wrAddr;
  logic [7:0] wrData;
  logic [6:0] rdAddr;
  logic [7:0] rdData;
  // Frame logic side
  modport owner (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
  // Storage side
  modport store (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface

// >>> design/stp_char_mem.sv
`timescale 1ns/1ps
module stp_char_mem
  import stp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Storage port
  stp_mem_if.store bus
);
  stp_mem_t st; // Cells plus registered read word
  stp_mem_t next_st; // Next value

  // Write one cell; read word is registered so data trail the address
  always_comb
  begin
    next_st = st;
    if (bus.wrEn)
    begin
      next_st.cells[bus.wrAddr] = bus.wrData;
    end
    next_st.rdData = st.cells[bus.rdAddr];
  end

  // Only the read word needs a defined reset value
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      st.rdData <= 8'h00;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign bus.rdData = st.rdData;
endmodule

// >>> design/stp_packetizer.sv
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Functional notes
// - UDP option sends port traffic as datagrams
// - Learning sends to last UDP source address
// - Custom rules only when enabled, both transports
// - Count threshold up to 128, default 50
// - Send when accumulated count reaches threshold
// - Wait expiry sends accumulated data, if any
// - Zero wait disables timer; default 100 ms
// - Flush character sends everything at once
// - Character length 5, 6, 7 or 8
// - One or two stops; odd, even, none parity
// - Custom baud used only when selected
// - Port 0 all modes, port 1 limited
// - Both debug means debug on port 0
// - Flow control only in RS-232; XON/XOFF both
// - RTS/CTS port 0 only; none disables throttling
// - Attention character detected when commands enabled
// - UDP mode disables TCP idle timeouts
module stp_packetizer
  import stp_pkg::*;
#(
  parameter int MS_CYCLES = `STP_MS_CYCLES
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Received characters from the UART logic, one stream per port
  input wire logic [1:0] rxValid,
  input wire logic [1:0][7:0] rxData,
  output logic [1:0] rxReady,
  // Frames to the network transport
  output logic [1:0] netValid,
  input wire logic [1:0] netReady,
  output logic [1:0][7:0] netData,
  output logic [1:0] netLast,
  output logic [1:0] netUdp,
  output logic [1:0][31:0] netDestIp,
  output logic [1:0][15:0] netDestPort,
  // UDP arrivals seen by the transport
  input wire logic [1:0] udpArrive,
  input wire logic [1:0][31:0] udpSrcIp,
  // Serial settings for the UART logic
  output logic [1:0][1:0] serCharLen,
  output logic [1:0] serTwoStop,
  output logic [1:0][1:0] serParity,
  output logic [1:0][31:0] serBaud,
  output logic [1:0][1:0] serMode,
  output logic [1:0][1:0] serFlow,
  // Transport and command hooks
  output logic [1:0] tcpTimeoutsOn,
  output logic [1:0] cmdAttn
);
  stp_state_t st; // All registered state
  stp_state_t next_st; // Next value of it
  logic [1:0] memWrEn; // Store strobe per port
  logic [1:0][6:0] memWrAddr; // Store address per port
  logic [1:0][7:0] memWrData; // Masked character per port
  logic [1:0][6:0] memRdAddr; // Fetch address per port
  logic [1:0][7:0] memRdData; // Registered fetch data per port
  logic [1:0][1:0] modeReq; // Mode as software wrote it
  logic [1:0][1:0] flowReq; // Flow control as software wrote it

  // Register file, millisecond prescaler and the two frame machines
  always_comb
  begin
    stp_port_t r;
    stp_port_t rp;
    logic [7:0] ofs;
    logic [7:0] mask;
    logic [7:0] ch;
    logic [7:0] thr;
    logic pktEn;
    logic take;
    logic wr;
    logic clrAttn;
    r = '0;
    rp = '0;
    ofs = {2'b00, paddr[5:0]};
    mask = 8'h00;
    ch = 8'h00;
    thr = 8'h01;
    pktEn = 1'b0;
    take = 1'b0;
    wr = 1'b0;
    clrAttn = 1'b0;
    next_st = st;
    memWrEn = '0;
    memWrAddr = '0;
    memWrData = '0;
    memRdAddr = '0;

    // Shared millisecond tick, one cycle wide
    next_st.msTick = 1'b0;
    next_st.msPre = st.msPre + 17'd1;
    if (st.msPre == 17'(MS_CYCLES - 1))
    begin
      next_st.msPre = 17'd0;
      next_st.msTick = 1'b1;
    end

    // Read word and error flag are caught in the setup cycle, so the
    // access phase can finish with no wait state
    if (psel && !penable)
    begin
      rp = st.port[paddr[6]];
      next_st.rdWord = 32'h0000_0000;
      next_st.badAddr = paddr[7];
      case (ofs)
        `STP_CTRL_OFS: next_st.rdWord = {16'h0000, rp.ctrl};
        `STP_COUNT_OFS: next_st.rdWord = {24'h00_0000, rp.countThr};
        `STP_WAIT_OFS: next_st.rdWord = {16'h0000, rp.waitMs};
        `STP_FLUSH_OFS: next_st.rdWord = {23'h00_0000, rp.flush};
        `STP_ATTN_OFS: next_st.rdWord = {24'h00_0000, rp.attnChar};
        `STP_BAUD_OFS: next_st.rdWord = rp.custBaud;
        `STP_DIP_OFS: next_st.rdWord = rp.destIp;
        `STP_DPORT_OFS: next_st.rdWord = {16'h0000, rp.destPort};
        `STP_STAT_OFS:
        begin
          next_st.rdWord[7:0] = rp.fill;
          next_st.rdWord[`STP_S_BUSY] = (rp.phase != STP_COLLECT);
          next_st.rdWord[`STP_S_ATTN] = rp.attnSeen;
        end
        `STP_LIP_OFS: next_st.rdWord = rp.learnedIp;
        default: next_st.badAddr = 1'b1;
      endcase
      if (paddr[7])
      begin
        next_st.rdWord = 32'h0000_0000;
      end
    end

    for (int p = 0; p < 2; p++)
    begin
      r = st.port[p];
      wr = psel && penable && pwrite && !paddr[7] && (paddr[6] == p[0]);
      clrAttn = 1'b0;

      // Software writes; writes to read-only words are ignored
      if (wr)
      begin
        case (ofs)
          `STP_CTRL_OFS: next_st.port[p].ctrl = pwdata[15:0];
          // Values past the buffer depth are clamped where used
          `STP_COUNT_OFS: next_st.port[p].countThr = pwdata[7:0];
          `STP_WAIT_OFS: next_st.port[p].waitMs = pwdata[15:0];
          `STP_FLUSH_OFS: next_st.port[p].flush = pwdata[8:0];
          `STP_ATTN_OFS: next_st.port[p].attnChar = pwdata[7:0];
          `STP_BAUD_OFS: next_st.port[p].custBaud = pwdata;
          `STP_DIP_OFS: next_st.port[p].destIp = pwdata;
          `STP_DPORT_OFS: next_st.port[p].destPort = pwdata[15:0];
          `STP_STAT_OFS: clrAttn = pwdata[`STP_S_ATTN];
          default:
          begin
          end
        endcase
      end

      // Incoming character trimmed to the configured length
      mask = 8'hFF >> (3 - r.ctrl[`STP_C_BITS +: 2]);
      ch = rxData[p] & mask;
      pktEn = r.ctrl[`STP_C_PKTEN];

      // Plain mode ships every character; custom mode uses the
      // threshold, clamped to what the buffer holds
      if (!pktEn)
      begin
        thr = 8'd1;
      end
      else if (r.countThr == 8'd0)
      begin
        thr = 8'd1;
      end
      else if (r.countThr > 8'(`STP_BUF_DEPTH))
      begin
        thr = 8'(`STP_BUF_DEPTH);
      end
      else
      begin
        thr = r.countThr;
      end

      take = rxValid[p] && (r.phase == STP_COLLECT);
      memWrEn[p] = take;
      memWrAddr[p] = r.fill[6:0];
      memWrData[p] = ch;
      memRdAddr[p] = r.sendIdx[6:0];

      // Attention character; the new hit wins over a clear in the same cycle
      next_st.port[p].attnHit = take && r.ctrl[`STP_C_ATEN] && (ch == r.attnChar);
      next_st.port[p].attnSeen = (r.attnSeen && !clrAttn) || next_st.port[p].attnHit;

      // Remember the sender of every datagram; used when learning is on in UDP mode
      if (udpArrive[p])
      begin
        next_st.port[p].learnedIp = udpSrcIp[p];
      end

      unique case (r.phase)
        STP_COLLECT:
        begin
          if (take)
          begin
            next_st.port[p].fill = r.fill + 8'd1;
            // First character of a frame starts the wait timer
            if (r.fill == 8'd0)
            begin
              next_st.port[p].msCnt = 16'd0;
              next_st.port[p].timing = 1'b1;
            end
            if ((r.fill + 8'd1) >= thr)
            begin
              next_st.port[p].phase = STP_FETCH;
              next_st.port[p].sendIdx = 8'd0;
              next_st.port[p].timing = 1'b0;
            end
            else if (pktEn && r.flush[8] && (ch == r.flush[7:0]))
            begin
              next_st.port[p].phase = STP_FETCH;
              next_st.port[p].sendIdx = 8'd0;
              next_st.port[p].timing = 1'b0;
            end
          end
          // Timer only runs with data held, so an expiry never sends empty
          else if (r.timing && st.msTick && pktEn && (r.waitMs != 16'd0))
          begin
            next_st.port[p].msCnt = r.msCnt + 16'd1;
            if ((r.msCnt + 16'd1) >= r.waitMs)
            begin
              next_st.port[p].phase = STP_FETCH;
              next_st.port[p].sendIdx = 8'd0;
              next_st.port[p].timing = 1'b0;
            end
          end
        end
        STP_FETCH:
        begin
          // Read word appears one edge after the address
          next_st.port[p].phase = STP_OFFER;
        end
        STP_OFFER:
        begin
          if (netReady[p])
          begin
            if ((r.sendIdx + 8'd1) == r.fill)
            begin
              // Frame done; count restarts with the next character
              next_st.port[p].fill = 8'd0;
              next_st.port[p].phase = STP_COLLECT;
            end
            else
            begin
              next_st.port[p].sendIdx = r.sendIdx + 8'd1;
              next_st.port[p].phase = STP_FETCH;
            end
          end
        end
      endcase
    end
  end

  // State register with synchronous reset
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      st <= '0;
      for (int p = 0; p < 2; p++)
      begin
        st.port[p].ctrl <= `STP_CTRL_RST;
        st.port[p].countThr <= `STP_COUNT_RST;
        st.port[p].waitMs <= `STP_WAIT_RST;
        st.port[p].flush <= `STP_FLUSH_RST;
        st.port[p].attnChar <= `STP_ATTN_RST;
        st.port[p].phase <= STP_COLLECT;
      end
    end
    else
    begin
      st <= next_st;
    end
  end

  // Zero-wait APB answer; unmapped words raise an error
  assign prdata = st.rdWord;
  assign pready = 1'b1;
  assign pslverr = psel && penable && st.badAddr;

  // Per-port storage, settings and transport hooks
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gPort
      stp_mem_if memBus ();

      assign memBus.wrEn = memWrEn[g];
      assign memBus.wrAddr = memWrAddr[g];
      assign memBus.wrData = memWrData[g];
      assign memBus.rdAddr = memRdAddr[g];
      assign memRdData[g] = memBus.rdData;

      stp_char_mem uMem (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .bus(memBus)
      );

      // Characters are refused while a frame is leaving
      assign rxReady[g] = (st.port[g].phase == STP_COLLECT);
      assign netValid[g] = (st.port[g].phase == STP_OFFER);
      assign netData[g] = memRdData[g];
      assign netLast[g] = ((st.port[g].sendIdx + 8'd1) == st.port[g].fill);
      assign netUdp[g] = st.port[g].ctrl[`STP_C_UDP];
      // Fixed destination must be programmed unless learning is on in UDP mode
      assign netDestIp[g] = (st.port[g].ctrl[`STP_C_UDP] && st.port[g].ctrl[`STP_C_LEARN])
        ? st.port[g].learnedIp : st.port[g].destIp;
      assign netDestPort[g] = st.port[g].destPort;
      // Idle and replace timers belong to connections only
      assign tcpTimeoutsOn[g] = !st.port[g].ctrl[`STP_C_UDP];
      assign cmdAttn[g] = st.port[g].attnHit;

      // Character framing handed to the UART
      assign serCharLen[g] = st.port[g].ctrl[`STP_C_BITS +: 2];
      assign serTwoStop[g] = st.port[g].ctrl[`STP_C_STOP2];
      assign serParity[g] = st.port[g].ctrl[`STP_C_PAR +: 2];
      // Custom rate wins only when it is selected
      assign serBaud[g] = st.port[g].ctrl[`STP_C_BCUST] ? st.port[g].custBaud
        : (st.port[g].ctrl[`STP_C_BIDX +: 2] == 2'd0) ? `STP_BAUD0
        : (st.port[g].ctrl[`STP_C_BIDX +: 2] == 2'd1) ? `STP_BAUD1
        : (st.port[g].ctrl[`STP_C_BIDX +: 2] == 2'd2) ? `STP_BAUD2 : `STP_BAUD3;

      assign modeReq[g] = st.port[g].ctrl[`STP_C_MODE +: 2];
      assign flowReq[g] = st.port[g].ctrl[`STP_C_FLOW +: 2];

      if (g == 0)
      begin : gMode0
        assign serMode[0] = modeReq[0];
      end
      else
      begin : gMode1
        // Port 1 has no RS-485, and yields debug to port 0
        assign serMode[1] = (modeReq[1][1]
          || ((modeReq[1] == `STP_MODE_DEBUG) && (modeReq[0] == `STP_MODE_DEBUG)))
          ? `STP_MODE_RS232 : modeReq[1];
      end

      // Throttling only in RS-232; hardware handshake only on port 0
      assign serFlow[g] = (serMode[g] != `STP_MODE_RS232) ? `STP_FLOW_NONE
        : (flowReq[g] == `STP_FLOW_XON) ? `STP_FLOW_XON
        : ((flowReq[g] == `STP_FLOW_RTS) && (g == 0)) ? `STP_FLOW_RTS
        : `STP_FLOW_NONE;
    end
  endgenerate
endmodule

// >>> verification/stp_packetizer_properties.sv
`timescale 1ns/1ps
module stp_packetizer_properties
  import stp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Character and frame handshakes
  input wire logic [1:0] rxValid,
  input wire logic [1:0] rxReady,
  input wire logic [1:0] netValid,
  input wire logic [1:0] netReady,
  input wire logic [1:0][7:0] netData,
  input wire logic [1:0] netLast,
  input wire logic [1:0] netUdp,
  input wire logic [1:0] udpArrive,
  // Effective settings and hooks
  input wire logic [1:0][1:0] serMode,
  input wire logic [1:0][1:0] serFlow,
  input wire logic [1:0] tcpTimeoutsOn,
  input wire logic [1:0] cmdAttn
);
  // One clock domain, so clock and reset are stated once
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // A stalled byte must not change, or the transport would see a torn frame
  a_byte_hold: assert property (netValid[0] && !netReady[0] |=> netValid[0] && $stable(netData[0]))
    else $error("frame byte moved before acceptance");
  // No new characters while a frame leaves, so counts restart cleanly
  a_rx_closed_send: assert property (netValid[0] |-> !rxReady[0])
    else $error("characters accepted while a frame leaves");
  a_udp_timeouts: assert property (tcpTimeoutsOn[0] == !netUdp[0])
    else $error("idle timeouts active in datagram mode");
  a_debug_once: assert property (!(serMode[0] == 2'h1 && serMode[1] == 2'h1))
    else $error("debug mode on both ports");
  a_port1_modes: assert property (serMode[1] <= 2'h1)
    else $error("half or full duplex mode on port 1");
  a_rts_port0: assert property (serFlow[1] != 2'h2)
    else $error("hardware flow control on port 1");
  a_flow_rs232: assert property (serMode[0] != 2'h0 |-> serFlow[0] == 2'h0)
    else $error("flow control outside RS-232 mode");
  a_attn_cause: assert property (cmdAttn[0] |-> $past(rxValid[0] && rxReady[0]))
    else $error("attention pulse without a taken character");
  // Main scenarios reached
  c_frame_end: cover property (netValid[0] && netReady[0] && netLast[0]);
  c_stall: cover property (netValid[0] && !netReady[0]);
  c_attn: cover property (cmdAttn[0]);
  c_arrive: cover property (udpArrive[0]);
endmodule

bind stp_packetizer stp_packetizer_properties u_props (
  .ref_clk(ref_clk), .reset_n(reset_n), .rxValid(rxValid), .rxReady(rxReady),
  .netValid(netValid), .netReady(netReady), .netData(netData), .netLast(netLast),
  .netUdp(netUdp), .udpArrive(udpArrive), .serMode(serMode), .serFlow(serFlow),
  .tcpTimeoutsOn(tcpTimeoutsOn), .cmdAttn(cmdAttn)
);

// >>> verification/stp_net_sink.sv
`timescale 1ns/1ps
module stp_net_sink
(
  // Clock
  input wire logic clk,
  // Frame byte stream from the packetizer
  input wire logic valid,
  input wire logic [7:0] data,
  input wire logic last,
  output logic ready,
  // Stall request from the bench
  input wire logic stall
);
  logic [7:0] got [$]; // Bytes taken since the bench last cleared them
  int frames; // Frames completed by a last byte
  initial
  begin
    ready = 1'b1;
    frames = 0;
  end
  // Take a byte at each handshake; while stalled, ready toggles so holds are exercised
  always @(posedge clk)
  begin
    if (valid === 1'b1 && ready === 1'b1)
    begin
      got.push_back(data);
      if (last === 1'b1)
        frames++;
    end
    ready <= stall ? ~ready : 1'b1;
  end
endmodule

// >>> verification/stp_packetizer_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, a, b); end end
module stp_packetizer_tb_top;
  typedef struct {logic [15:0] ctrl; logic [10:0] cfg; logic [31:0] baud;} stp_tb_row_t;
  logic ref_clk;
  logic reset_n;
  logic [7:0] paddr;
  logic psel, penable, pwrite;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr;
  logic [1:0] rxValid, rxReady, netValid, netLast, netUdp, udpArrive, serTwoStop;
  logic [1:0][7:0] rxData, netData;
  wire logic [1:0] netReady;
  logic [1:0][31:0] netDestIp, udpSrcIp, serBaud;
  logic [1:0][15:0] netDestPort;
  logic [1:0][1:0] serCharLen, serParity, serMode, serFlow;
  logic [1:0] tcpTimeoutsOn, cmdAttn;
  logic stall0, errq;
  logic [31:0] rdq;
  int mismatches, cmp_count, cyc, attnCnt, frames0;
  // Control word in, {length, two stops, parity, mode, flow, udp, timeouts} and baud out
  stp_tb_row_t rows [6] = '{
    '{16'hC300, {2'h3, 1'h0, 2'h0, 2'h0, 2'h0, 1'h0, 1'h1}, 32'h0001_C200},
    '{16'h0C41, {2'h0, 1'h1, 2'h1, 2'h0, 2'h1, 1'h1, 1'h0}, 32'h0000_2580},
    '{16'h5190, {2'h1, 1'h0, 2'h2, 2'h1, 2'h0, 1'h0, 1'h1}, 32'h0000_4B00},
    '{16'h8280, {2'h2, 1'h0, 2'h0, 2'h0, 2'h2, 1'h0, 1'h1}, 32'h0000_E100},
    '{16'h2330, {2'h3, 1'h0, 2'h0, 2'h3, 2'h0, 1'h0, 1'h1}, 32'h0000_1F40},
    '{16'h1B20, {2'h3, 1'h0, 2'h3, 2'h2, 2'h0, 1'h0, 1'h1}, 32'h0000_2580}};
  // Short millisecond so timer cases stay brief
  stp_packetizer #(.MS_CYCLES(10)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxValid(rxValid),
    .rxData(rxData), .rxReady(rxReady), .netValid(netValid), .netReady(netReady),
    .netData(netData), .netLast(netLast), .netUdp(netUdp), .netDestIp(netDestIp),
    .netDestPort(netDestPort), .udpArrive(udpArrive), .udpSrcIp(udpSrcIp),
    .serCharLen(serCharLen), .serTwoStop(serTwoStop), .serParity(serParity),
    .serBaud(serBaud), .serMode(serMode), .serFlow(serFlow),
    .tcpTimeoutsOn(tcpTimeoutsOn), .cmdAttn(cmdAttn));
  stp_net_sink u_sink0 (.clk(ref_clk), .valid(netValid[0]), .data(netData[0]),
    .last(netLast[0]), .ready(netReady[0]), .stall(stall0));
  stp_net_sink u_sink1 (.clk(ref_clk), .valid(netValid[1]), .data(netData[1]),
    .last(netLast[1]), .ready(netReady[1]), .stall(1'b0));
  // Clock
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  // Attention pulse count and hang guard
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cmdAttn[0] === 1'b1)
      attnCnt++;
    if (cyc == 20000)
    begin
      mismatches++;
      test_done();
    end
  end
  task automatic test_done();
    $display("Counts: compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Access phase ends at the first edge with pready high; answer taken there
    @(posedge ref_clk);
    while (pready !== 1'b1)
    begin
      @(posedge ref_clk);
    end
    errq = pslverr;
    rdq = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0000_0000);
    `CHK(rdq, e)
  endtask
  // Offer one character and hold it until taken; the caller idles the line afterwards
  task automatic put(input logic [7:0] c);
    rxValid[0] <= 1'b1;
    rxData[0] <= c;
    #1;
    while (rxReady[0] !== 1'b1)
    begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
  endtask
  // Released line shows the inverse, never the stale character
  task automatic rxIdle();
    rxValid[0] <= 1'b0;
    rxData[0] <= ~rxData[0];
  endtask
  // Wait boundedly for the next frame and check its length and end bytes
  task automatic expectFrame(input int n, input logic [7:0] b0, input logic [7:0] bl);
    int k;
    k = 0;
    while (u_sink0.frames == frames0 && k < 400)
    begin
      @(posedge ref_clk);
      k++;
    end
    #1;
    `CHK(u_sink0.got.size(), n)
    `CHK(u_sink0.got[0], b0)
    `CHK(u_sink0.got[n-1], bl)
    u_sink0.got.delete();
    frames0 = u_sink0.frames;
  endtask
  task automatic arrive(input logic [31:0] ip);
    udpArrive[0] <= 1'b1;
    udpSrcIp[0] <= ip;
    @(posedge ref_clk);
    udpArrive[0] <= 1'b0;
    @(posedge ref_clk);
  endtask
  initial
  begin
    {reset_n, psel, penable, pwrite, paddr, pwdata, stall0} = '0;
    {rxValid, rxData, udpArrive, udpSrcIp} = '0;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    // Reset values
    rdchk(8'h04, 32'h0000_0032);
    rdchk(8'h08, 32'h0000_0064);
    rdchk(8'h0C, 32'h0000_0000);
    rdchk(8'h10, 32'h0000_002B);
    rdchk(8'h00, 32'h0000_C300);
    apb(8'h80, 1'b0, 32'h0000_0000);
    `CHK({errq, rdq}, {1'b1, 32'h0000_0000})
    // Serial settings table
    apb(8'h14, 1'b1, 32'h0000_1F40);
    foreach (rows[i])
    begin
      apb(8'h00, 1'b1, {16'h0000, rows[i].ctrl});
      rdchk(8'h00, {16'h0000, rows[i].ctrl});
      `CHK({serCharLen[0], serTwoStop[0], serParity[0], serMode[0], serFlow[0], netUdp[0], tcpTimeoutsOn[0]}, rows[i].cfg)
      `CHK(serBaud[0], rows[i].baud)
    end
    apb(8'h00, 1'b1, 32'h0000_C310);
    apb(8'h40, 1'b1, 32'h0000_C310);
    // Let the write land before looking at the effective modes
    @(posedge ref_clk);
    `CHK({serMode[1], serMode[0]}, {2'h0, 2'h1})
    apb(8'h00, 1'b1, 32'h0000_C300);
    // Without custom rules each character is a frame of its own
    put(8'h41);
    rxIdle();
    expectFrame(1, 8'h41, 8'h41);
    // Count threshold, back to back, with the transport stalling
    apb(8'h04, 1'b1, 32'h0000_0003);
    apb(8'h00, 1'b1, 32'h0000_C304);
    stall0 <= 1'b1;
    put(8'h11);
    put(8'h22);
    put(8'h33);
    rxIdle();
    expectFrame(3, 8'h11, 8'h33);
    stall0 <= 1'b0;
    // Largest count
    apb(8'h04, 1'b1, 32'h0000_0080);
    for (int i = 0; i < 128; i++)
      put(i[7:0]);
    rxIdle();
    expectFrame(128, 8'h00, 8'h7F);
    // Flush character ends the frame; attention char ignored while commands are off
    apb(8'h04, 1'b1, 32'h0000_0032);
    apb(8'h0C, 1'b1, 32'h0000_010A);
    put(8'h2B);
    put(8'h0A);
    rxIdle();
    expectFrame(2, 8'h2B, 8'h0A);
    `CHK(attnCnt, 0)
    // Wait expiry sends the partial frame, but not too early
    apb(8'h08, 1'b1, 32'h0000_0002);
    put(8'h55);
    rxIdle();
    repeat (5) @(posedge ref_clk);
    `CHK(u_sink0.frames, frames0)
    expectFrame(1, 8'h55, 8'h55);
    repeat (60) @(posedge ref_clk);
    `CHK(u_sink0.frames, frames0)
    // Zero wait holds the data until the flush character
    apb(8'h08, 1'b1, 32'h0000_0000);
    put(8'h66);
    rxIdle();
    repeat (300) @(posedge ref_clk);
    `CHK(u_sink0.frames, frames0)
    put(8'h0A);
    rxIdle();
    expectFrame(2, 8'h66, 8'h0A);
    // Attention character with commands on
    apb(8'h00, 1'b1, 32'h0000_C30C);
    put(8'h2B);
    rxIdle();
    repeat (3) @(posedge ref_clk);
    `CHK(attnCnt, 1)
    // Status: one character held, not busy, attention seen
    rdchk(8'h20, 32'h0000_0201);
    // Flush the held attention character so the next frame starts empty
    put(8'h0A);
    rxIdle();
    expectFrame(2, 8'h2B, 8'h0A);
    // Datagram mode with reply-address learning, then fixed destination
    apb(8'h18, 1'b1, 32'h0A00_0001);
    apb(8'h1C, 1'b1, 32'h0000_1234);
    apb(8'h00, 1'b1, 32'h0000_C303);
    arrive(32'hC0A8_0005);
    `CHK(netDestIp[0], 32'hC0A8_0005)
    arrive(32'hC0A8_0009);
    `CHK(netDestIp[0], 32'hC0A8_0009)
    rdchk(8'h24, 32'hC0A8_0009);
    apb(8'h00, 1'b1, 32'h0000_C301);
    @(posedge ref_clk);
    `CHK({netUdp[0], netDestIp[0], netDestPort[0]}, {1'b1, 32'h0A00_0001, 16'h1234})
    put(8'h77);
    rxIdle();
    expectFrame(1, 8'h77, 8'h77);
    test_done();
  end
endmodule
